//--- design/svdc_consts.vh
// Constants for the supply voltage detect control block.
// Assumes inclusion by bare name from design files.
`ifndef SVDC_CONSTS_VH
`define SVDC_CONSTS_VH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define SVDC_OFF_CTRL      4'h0
`define SVDC_OFF_STATUS    4'h4
`define SVDC_OFF_MASK      4'h8
`define SVDC_OFF_GLOBAL    4'hc

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define SVDC_BIT_DIR       7
`define SVDC_BIT_UNIMP     6
`define SVDC_BIT_STABLE    5
`define SVDC_BIT_PWR       4
`define SVDC_LVL_HI        3
`define SVDC_LVL_LO        0
`define SVDC_CTRL_RST      8'h05
`define SVDC_LVL_EXT       4'hf
`define SVDC_LVL_MAX       4'he
`define SVDC_LVL_MIN       4'h0

// ----------------------------------------------------------------------------
// Status and mask fields
// ----------------------------------------------------------------------------
`define SVDC_BIT_EVENT     0

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define SVDC_CLK_MHZ       250
`define SVDC_SETTLE_NS     20000
`define SVDC_SETTLE_CYC    ((`SVDC_SETTLE_NS * `SVDC_CLK_MHZ + 999) / 1000)

`endif

//--- design/svdc_sync.v
// Three-stage synchroniser with agreement filter.
// Assumes the input is asynchronous to clk_i.
`timescale 1ns/1ps

module svdc_sync
(
    input  wire clk_i,
    input  wire rst_i,
    input  wire async_i,
    output reg  level_o
);

    reg s1_q;
    reg s2_q;
    reg s3_q;

    // ------------------------------------------------------------------------
    // Stages
    // ------------------------------------------------------------------------
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s1_q    <= 1'b0;
            s2_q    <= 1'b0;
            s3_q    <= 1'b0;
            level_o <= 1'b0;
        end
        else
        begin
            s1_q <= async_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q)
            begin
                level_o <= s3_q;
            end
        end
    end

endmodule

//--- design/svdc_top.v
// Supply voltage detect control: register file, settle timer, event logic.
// Assumes analog comparator outputs arrive asynchronously; Wishbone classic.
//
// Overview of operation
// - Detector powered and active only while power enable bit 4 is one.
// - Reference stable flag bit 5 is read only, set after settle.
// - Detector events are suppressed until the stable flag is set.
// - Direction zero detects falling to trip; one detects rising to it.
// - Four bit trip level selects fifteen settings, 0000 min, 1110 max.
// - Level 1111 routes comparator input from the external trip pin.
// - Trip crossing sets the event flag; stays set until software clears.
// - Interrupt needs flag, detector enable and global enable, after stable.
// - Settle interval is timed; crossings before expiry set no flag.
// - Detector keeps running in sleep; a crossing raises wake request if the event mask bit is set.
// - Reset gives control 0x05; bit 6 unimplemented, reads zero.
`timescale 1ns/1ps
`include "svdc_consts.vh"

module svdc_top
#(
    parameter SETTLE_CYC = `SVDC_SETTLE_CYC
)
(
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [3:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    input  wire        below_trip_i,
    input  wire        above_trip_i,
    input  wire        sleep_i,
    output reg         detector_power_o,
    output reg  [3:0]  trip_level_o,
    output reg         external_trip_input_sel_o,
    output wire        irq_o,
    output wire        wake_o
);

    // ------------------------------------------------------------------------
    // Constants
    // ------------------------------------------------------------------------
    localparam [7:0]  CTRL_RST    = `SVDC_CTRL_RST;
    localparam [31:0] SETTLE_LAST = SETTLE_CYC - 1;

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    reg        trip_direction_select_q;
    reg        detector_power_enable_q;
    reg [3:0]  trip_level_select_q;
    reg        reference_stable_flag_q;
    reg        voltage_event_flag_q;
    reg        voltage_event_irq_enable_q;
    reg        global_irq_enable_q;
    reg [31:0] settle_cnt_q;
    reg        tripped_q;

    wire       below_s;
    wire       above_s;
    wire       access;
    wire       wr;
    wire       hit_lane0;
    wire       crossing;
    wire       event_set;
    wire       event_clr;
    wire [7:0] ctrl_rd;
    wire [1:0] trip_raw;
    wire [1:0] trip_s;
    wire       sel_ctrl;
    wire       sel_status;
    wire       sel_mask;
    wire       sel_global;

    genvar     gi;

    // ------------------------------------------------------------------------
    // Comparator input synchronisers
    // ------------------------------------------------------------------------
    // One synchroniser per comparator output
    assign trip_raw = {above_trip_i, below_trip_i};

    generate
        for (gi = 0; gi < 2; gi = gi + 1)
        begin : g_sync
            svdc_sync u_sync
            (
                .clk_i   (clk_i),
                .rst_i   (rst_i),
                .async_i (trip_raw[gi]),
                .level_o (trip_s[gi])
            );
        end
    endgenerate

    assign below_s = trip_s[0];
    assign above_s = trip_s[1];

    // ------------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------------
    assign access    = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr        = access && wb_we_i;
    assign hit_lane0 = wb_sel_i[0];

    function is_off;
        input [3:0] adr;
        input [3:0] off;
        begin
            is_off = (adr == off);
        end
    endfunction

    // Register selects
    assign sel_ctrl   = is_off(wb_adr_i, `SVDC_OFF_CTRL);
    assign sel_status = is_off(wb_adr_i, `SVDC_OFF_STATUS);
    assign sel_mask   = is_off(wb_adr_i, `SVDC_OFF_MASK);
    assign sel_global = is_off(wb_adr_i, `SVDC_OFF_GLOBAL);

    // Bit 6 reads zero
    assign ctrl_rd = {trip_direction_select_q, 1'b0,
                      reference_stable_flag_q, detector_power_enable_q,
                      trip_level_select_q};

    // ------------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------------
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            trip_direction_select_q <= CTRL_RST[`SVDC_BIT_DIR];
            detector_power_enable_q <= CTRL_RST[`SVDC_BIT_PWR];
            trip_level_select_q     <=
                CTRL_RST[`SVDC_LVL_HI:`SVDC_LVL_LO];
        end
        else if (wr && hit_lane0 && sel_ctrl)
        begin
            // Stable bit is not writable
            trip_direction_select_q <= wb_dat_i[`SVDC_BIT_DIR];
            detector_power_enable_q <= wb_dat_i[`SVDC_BIT_PWR];
            trip_level_select_q     <=
                wb_dat_i[`SVDC_LVL_HI:`SVDC_LVL_LO];
        end
    end

    // ------------------------------------------------------------------------
    // Mask and global enable
    // ------------------------------------------------------------------------
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            voltage_event_irq_enable_q <= 1'b0;
            global_irq_enable_q        <= 1'b0;
        end
        else if (wr && hit_lane0)
        begin
            if (sel_mask)
            begin
                voltage_event_irq_enable_q <= wb_dat_i[`SVDC_BIT_EVENT];
            end
            if (sel_global)
            begin
                global_irq_enable_q <= wb_dat_i[0];
            end
        end
    end

    // ------------------------------------------------------------------------
    // Settle timer
    // ------------------------------------------------------------------------
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            settle_cnt_q            <= 32'h0;
            reference_stable_flag_q <= 1'b0;
        end
        else if (!detector_power_enable_q)
        begin
            settle_cnt_q            <= 32'h0;
            reference_stable_flag_q <= 1'b0;
        end
        else if (!reference_stable_flag_q)
        begin
            if (settle_cnt_q >= SETTLE_LAST)
            begin
                reference_stable_flag_q <= 1'b1;
            end
            else
            begin
                settle_cnt_q <= settle_cnt_q + 32'h1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Detector outputs
    // ------------------------------------------------------------------------
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            detector_power_o          <= 1'b0;
            trip_level_o              <= `SVDC_LVL_MIN;
            external_trip_input_sel_o <= 1'b0;
        end
        else
        begin
            detector_power_o          <= detector_power_enable_q;
            trip_level_o              <= trip_level_select_q;
            external_trip_input_sel_o <=
                (trip_level_select_q == `SVDC_LVL_EXT);
        end
    end

    // ------------------------------------------------------------------------
    // Event detection
    // ------------------------------------------------------------------------
    // Level to or past trip in the chosen direction
    assign crossing = trip_direction_select_q ? above_s : below_s;

    // Previous level for edge detection
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            tripped_q <= 1'b0;
        end
        else
        begin
            tripped_q <= crossing;
        end
    end

    // Sleep does not gate detection
    assign event_set = detector_power_enable_q && reference_stable_flag_q
                       && crossing && !tripped_q;
    assign event_clr = wr && hit_lane0 && sel_status
                       && wb_dat_i[`SVDC_BIT_EVENT];

    // Set wins over a clear in the same cycle
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            voltage_event_flag_q <= 1'b0;
        end
        else if (event_set)
        begin
            voltage_event_flag_q <= 1'b1;
        end
        else if (event_clr)
        begin
            voltage_event_flag_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Interrupt and wake
    // ------------------------------------------------------------------------
    // No interrupt request before the reference has settled
    assign irq_o  = voltage_event_flag_q && voltage_event_irq_enable_q
                    && global_irq_enable_q
                    && reference_stable_flag_q;
    // Wake ignores the global enable
    assign wake_o = sleep_i && voltage_event_flag_q
                    && voltage_event_irq_enable_q;

    // ------------------------------------------------------------------------
    // Bus answer
    // ------------------------------------------------------------------------
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end
        else
        begin
            wb_ack_o <= access;
            if (access && !wb_we_i)
            begin
                case (wb_adr_i)
                    `SVDC_OFF_CTRL:   wb_dat_o <= {24'h0, ctrl_rd};
                    `SVDC_OFF_STATUS: wb_dat_o <= {31'h0, voltage_event_flag_q};
                    `SVDC_OFF_MASK:
                        wb_dat_o <= {31'h0, voltage_event_irq_enable_q};
                    `SVDC_OFF_GLOBAL: wb_dat_o <= {31'h0, global_irq_enable_q};
                    default:          wb_dat_o <= 32'h0;
                endcase
            end
        end
    end

endmodule

//--- tb/svdc_props.sv
// Port checker for the voltage detect control block.
// Assumes one clock domain; bound to svdc_top below.
`timescale 1ns/1ps
module svdc_props
#(
    parameter SETTLE_CYC = 8
)
(
    input wire        clk_i,
    input wire        rst_i,
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_we_i,
    input wire [3:0]  wb_adr_i,
    input wire [3:0]  wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire        wb_ack_o,
    input wire        sleep_i,
    input wire        detector_power_o,
    input wire [3:0]  trip_level_o,
    input wire        external_trip_input_sel_o,
    input wire        irq_o,
    input wire        wake_o
);
    // ------------------------------------------------------------
    // Port relations
    // ------------------------------------------------------------
    wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wr_ctl = take && wb_we_i && wb_adr_i == 4'h0 && wb_sel_i[0];
    wire rd_ctl = wb_ack_o && !wb_we_i && wb_adr_i == 4'h0;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_answer: assert property (take |=> wb_ack_o)
        else $error("request not acknowledged");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_pwr_write: assert property (wr_ctl |-> ##3
        detector_power_o == $past(wb_dat_i[4], 3)) else $error("power");
    a_lvl_write: assert property (wr_ctl |-> ##3
        trip_level_o == $past(wb_dat_i[3:0], 3)) else $error("level");
    a_ext_select: assert property
        (external_trip_input_sel_o == (trip_level_o == 4'hf))
        else $error("external select");
    a_reset_level: assert property ($fell(rst_i) |=>
        trip_level_o == 4'h5 && !detector_power_o) else $error("reset");
    a_bit6_zero: assert property (rd_ctl |-> !wb_dat_o[6])
        else $error("bit 6 set");
    a_wake_sleep: assert property (wake_o |-> sleep_i)
        else $error("wake while awake");
    a_irq_wake: assert property (irq_o && sleep_i |-> wake_o)
        else $error("no wake");
    a_irq_powered: assert property (irq_o |-> detector_power_o)
        else $error("request while off");
endmodule
bind svdc_top svdc_props #(.SETTLE_CYC(SETTLE_CYC)) u_props
(
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .sleep_i(sleep_i),
    .detector_power_o(detector_power_o), .trip_level_o(trip_level_o),
    .external_trip_input_sel_o(external_trip_input_sel_o),
    .irq_o(irq_o), .wake_o(wake_o)
);

//--- tb/testbench.sv
// Self-checking bench for the voltage detect control block.
// Assumes svdc_top with a short settle count.
`timescale 1ns/1ps
module testbench;
    localparam ST = 32;
    logic        clk = 0, rst = 1, cyc = 0, we = 0;
    logic        blw = 0, abv = 0, slp = 0;
    logic [3:0]  adr = 0, sel = 4'hf, lvl;
    logic [31:0] wd = 0, rd, dat;
    logic [7:0]  c;
    logic        ack, pwr, xs, irq, wk;
    int          n_fail = 0, checks = 0, i, k;
    always #2 clk = ~clk;
    svdc_top #(.SETTLE_CYC(ST)) uut
    (
        .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd),
        .wb_dat_o(dat), .wb_ack_o(ack), .below_trip_i(blw),
        .above_trip_i(abv), .sleep_i(slp), .detector_power_o(pwr),
        .trip_level_o(lvl), .external_trip_input_sel_o(xs),
        .irq_o(irq), .wake_o(wk)
    );
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task give_verdict;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: %h not %h", $time, got, exp);
        end
    endtask
    function logic [31:0] ctrl_word(input logic d, input logic s,
                                    input logic p, input logic [3:0] l);
        return {24'h0, d, 1'b0, s, p, l};
    endfunction
    function logic req_exp(input logic f, input logic m, input logic g);
        return f & m & g;
    endfunction
    task wb(input logic w, input logic [3:0] a, input logic [31:0] v,
            input logic [3:0] s = 4'hf);
        int t;
        cyc <= 1;
        we <= w;
        adr <= a;
        wd <= v;
        sel <= s;
        for (t = 0; t < 20; t++)
        begin
            @(posedge clk);
            if (ack === 1'b1)
                break;
        end
        if (t == 20)
        begin
            n_fail++;
            give_verdict;
        end
        rd = dat;
        cyc <= 0;
        @(posedge clk);
    endtask
    task trip(input logic b, input logic a);
        blw <= b;
        abv <= a;
        repeat (8) @(posedge clk);
    endtask
    task sts(input logic e);
        wb(0, 4'h4, 0);
        chk(rd, e);
    endtask
    task settle;
        for (k = 0; k < 20; k++)
        begin
            wb(0, 4'h0, 0);
            if (rd[5] === 1'b1)
                break;
        end
        chk(rd[5], 1);
    endtask
    initial
    begin
        k = $urandom(32'h84d8);
        repeat (16) @(posedge clk);
        rst <= 0;
        wb(0, 4'h0, 0);
        chk(rd, ctrl_word(0, 0, 0, 4'h5));
        wb(1, 4'h0, 32'hff);
        wb(1, 4'h2, 32'hff);
        trip(0, 1);
        wb(0, 4'h0, 0);
        chk(rd, ctrl_word(1, 0, 1, 4'hf));
        sts(0);
        settle;
        trip(0, 0);
        sts(0);
        wb(0, 4'h2, 0);
        chk(rd, 0);
        wb(1, 4'h0, 32'h00, 4'he);
        wb(0, 4'h0, 0);
        chk(rd, ctrl_word(1, 1, 1, 4'hf));
        chk({pwr, xs}, 2'b11);
        for (i = 0; i < 8; i++)
        begin
            c = $urandom;
            if (i < 2)
                c[3:0] = {4{i[0]}};
            wb(1, 4'h0, {c[7], 3'b000, c[3:0]});
            wb(1, 4'h0, {c[7], 3'b001, c[3:0]});
            wb(1, 4'h4, 1);
            wb(1, 4'h8, c[6]);
            wb(1, 4'hc, c[5]);
            slp <= c[4];
            settle;
            chk({lvl, xs}, {c[3:0], c[3:0] == 4'hf});
            trip(c[7], !c[7]);
            sts(0);
            trip(!c[7], c[7]);
            sts(1);
            chk(irq, req_exp(1, c[6], c[5]));
            chk(wk, req_exp(1, c[6], c[4]));
            trip(0, 0);
            sts(1);
            wb(1, 4'h4, 1);
            sts(0);
        end
        wb(1, 4'h8, 1);
        wb(1, 4'hc, 1);
        wb(1, 4'h0, 32'h85);
        wb(1, 4'h0, 32'h95);
        wb(1, 4'h4, 1);
        slp <= 1;
        settle;
        trip(0, 1);
        chk(irq, 1);
        chk(wk, 1);
        wb(1, 4'h0, 32'h05);
        chk(irq, 0);
        sts(1);
        wb(1, 4'h4, 1);
        wb(1, 4'h0, 32'h05);
        wb(0, 4'h0, 0);
        chk(rd, ctrl_word(0, 0, 0, 4'h5));
        chk(pwr, 0);
        trip(1, 1);
        sts(0);
        give_verdict;
    end
endmodule
